// ===== verilog/psr_status_bank.sv
// psr_status_bank: processor status register bank of one tile.
// assumes: the local core issues one status read or write per cycle;
// boot pins and oscillators are asynchronous, OTP data is on mclk.
`timescale 1ns/100ps
module psr_status_bank
  import psr_pkg::*;
#(
  parameter int DIV_RATIO = 8
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // status-register access from the local core
  input  wire logic        ps_rd,
  input  wire logic        ps_wr,
  input  wire logic [7:0]  ps_num,
  input  wire logic [31:0] ps_wdata,
  output logic [31:0]      ps_rdata,
  output logic             ps_rvalid,
  // event and interrupt vectoring
  input  wire logic        vec_take,
  input  wire logic [15:0] vec_resource,
  output logic [31:0]      vec_addr,
  output logic             vec_addr_valid,
  // memory base
  output logic [31:0]      ram_base,
  // clock divider
  input  wire logic        cores_all_paused,
  output logic             tile_clk_en,
  output logic             tile_clk_slow,
  // boot and OTP information
  input  wire logic [7:0]  boot_select_pins,
  input  wire logic [7:0]  switch_tile_num,
  input  wire logic        otp_boot_enabled,
  input  wire logic [31:0] otp_security_word,
  // ring oscillators
  output logic             osc_tile_run,
  output logic             osc_periph_run,
  input  wire logic        osc_tile_cell,
  input  wire logic        osc_tile_wire,
  input  wire logic        osc_periph_cell,
  input  wire logic        osc_periph_wire
);

  localparam int DW = (DIV_RATIO > 1) ? $clog2(DIV_RATIO) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV_RATIO - 1);

  typedef struct packed {
    logic [29:0] ram_hi;
    logic [15:0] vbase_hi;
    logic        div_en;
    logic        div_dyn;
    logic [1:0]  osc_en;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    logic [1:0]  cap_cnt;
    logic        captured;
    logic [7:0]  boot_pins;
    logic [7:0]  tile_num;
    logic        otp_boot;
    logic [31:0] sec_word;
    logic [31:0] rdata;
    logic        rvalid;
    logic [31:0] vaddr;
    logic        vvalid;
    logic [DW-1:0] div_cnt;
    logic        clk_en;
    logic        slow;
  } psr_st_t;

  psr_st_t q;
  psr_st_t d;

  logic [OSC_COUNT_W-1:0] cnt_tc;
  logic [OSC_COUNT_W-1:0] cnt_tw;
  logic [OSC_COUNT_W-1:0] cnt_pc;
  logic [OSC_COUNT_W-1:0] cnt_pw;
  logic                   slow_now;

  // ---------------------------------------------------------------
  // oscillator counters
  // ---------------------------------------------------------------
  psr_osc_count #(.W(OSC_COUNT_W)) u_tile_cell (
    .mclk   (mclk),
    .run    (q.osc_en[OSC_TILE_BIT]),
    .osc_in (osc_tile_cell),
    .count  (cnt_tc)
  );

  psr_osc_count #(.W(OSC_COUNT_W)) u_tile_wire (
    .mclk   (mclk),
    .run    (q.osc_en[OSC_TILE_BIT]),
    .osc_in (osc_tile_wire),
    .count  (cnt_tw)
  );

  psr_osc_count #(.W(OSC_COUNT_W)) u_periph_cell (
    .mclk   (mclk),
    .run    (q.osc_en[OSC_PERIPH_BIT]),
    .osc_in (osc_periph_cell),
    .count  (cnt_pc)
  );

  psr_osc_count #(.W(OSC_COUNT_W)) u_periph_wire (
    .mclk   (mclk),
    .run    (q.osc_en[OSC_PERIPH_BIT]),
    .osc_in (osc_periph_wire),
    .count  (cnt_pw)
  );

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  // unmapped numbers and reserved fields read as zero
  function automatic logic [31:0] read_word(input logic [7:0] num,
                                            input psr_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (num)
      RAM_BASE_ADDRESS_IDX:      w = {s.ram_hi, 2'b00};
      VECTOR_BASE_ADDRESS_IDX:   w = {s.vbase_hi, 16'h0000};
      TILE_POWER_CONTROL_IDX: begin
        w[DIV_EN_BIT]  = s.div_en;
        w[DIV_DYN_BIT] = s.div_dyn;
      end
      TILE_BOOT_STATUS_IDX: begin
        w[BOOT_TILE_LSB +: 8] = s.tile_num;
        w[BOOT_OTP_BIT]       = s.otp_boot;
        w[7:0]                = s.boot_pins;
      end
      SECURITY_CONFIG_COPY_IDX:  w = s.sec_word;
      OSCILLATOR_CONTROL_IDX:    w = {30'h0, s.osc_en};
      TILE_CELL_OSC_COUNT_IDX:   w = {16'h0000, cnt_tc};
      TILE_WIRE_OSC_COUNT_IDX:   w = {16'h0000, cnt_tw};
      PERIPH_CELL_OSC_COUNT_IDX: w = {16'h0000, cnt_pc};
      PERIPH_WIRE_OSC_COUNT_IDX: w = {16'h0000, cnt_pw};
      default:                   w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // static mode slows always, dynamic only while all cores wait
  assign slow_now = q.div_en && (!q.div_dyn || cores_all_paused);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;

    // status-register writes; read-only numbers fall through
    if (ps_wr) begin
      unique case (ps_num)
        RAM_BASE_ADDRESS_IDX:
          d.ram_hi = ps_wdata[31:RAM_BASE_LSB];
        VECTOR_BASE_ADDRESS_IDX:
          d.vbase_hi = ps_wdata[31:VEC_BASE_LSB];
        TILE_POWER_CONTROL_IDX: begin
          d.div_en  = ps_wdata[DIV_EN_BIT];
          d.div_dyn = ps_wdata[DIV_DYN_BIT];
        end
        OSCILLATOR_CONTROL_IDX:
          d.osc_en = ps_wdata[1:0];
        default: ;
      endcase
    end

    // reads answer one cycle later; a write in the same cycle is
    // not yet visible, which keeps the read path short
    d.rvalid = ps_rd;
    if (ps_rd) begin
      d.rdata = read_word(ps_num, q);
    end

    // vector address for the event being taken
    d.vvalid = vec_take;
    if (vec_take) begin
      d.vaddr = {q.vbase_hi, vec_resource};
    end

    // boot pins pass two stages, then are caught once after reset
    d.pin_s1 = boot_select_pins;
    d.pin_s2 = q.pin_s1;
    if (!q.captured) begin
      if (q.cap_cnt == BOOT_CAPTURE_CNT) begin
        d.captured  = 1'b1;
        d.boot_pins = q.pin_s2;
        d.tile_num  = switch_tile_num;
        d.otp_boot  = otp_boot_enabled;
        d.sec_word  = otp_security_word;
      end else begin
        d.cap_cnt = q.cap_cnt + 2'h1;
      end
    end

    // power-saving divider: one enable pulse per DIV_RATIO cycles
    d.slow = slow_now;
    if (slow_now) begin
      d.div_cnt = (q.div_cnt == DIV_LAST) ? '0 : q.div_cnt + DW'(1);
      d.clk_en  = (q.div_cnt == DIV_LAST);
    end else begin
      d.div_cnt = '0;
      d.clk_en  = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q           <= '0;
      q.ram_hi    <= RAM_BASE_RST[31:RAM_BASE_LSB];
      q.div_en    <= 1'b0;
      q.div_dyn   <= 1'b0;
      q.osc_en    <= 2'b00;
      q.clk_en    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ps_rdata       = q.rdata;
  assign ps_rvalid      = q.rvalid;
  assign vec_addr       = q.vaddr;
  assign vec_addr_valid = q.vvalid;
  assign ram_base       = {q.ram_hi, 2'b00};
  assign tile_clk_en    = q.clk_en;
  assign tile_clk_slow  = q.slow;
  assign osc_tile_run   = q.osc_en[OSC_TILE_BIT];
  assign osc_periph_run = q.osc_en[OSC_PERIPH_BIT];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_RAM_WRITE: assert property (
    ps_wr && ps_num == RAM_BASE_ADDRESS_IDX
    |=> ram_base == {$past(ps_wdata[31:2]), 2'b00})
    else $error("ram base did not take written value");

  AST_RAM_LOW_ZERO: assert property (
    ps_rvalid && $past(ps_num) == RAM_BASE_ADDRESS_IDX && !$past(ps_wr)
    |-> ps_rdata[1:0] == 2'b00 && ps_rdata == ram_base)
    else $error("ram base readback wrong");

  AST_RAM_RESET: assert property (
    $rose(rstn) |-> ram_base == RAM_BASE_RST)
    else $error("ram base reset value wrong");

  AST_VEC_BUILD: assert property (
    vec_take ##1 vec_addr_valid
    |-> vec_addr == {$past(q.vbase_hi), $past(vec_resource)})
    else $error("vector address not built from base and resource");

  AST_VBASE_READ: assert property (
    ps_wr && ps_num == VECTOR_BASE_ADDRESS_IDX ##1 !ps_wr ##1
    ps_rd && ps_num == VECTOR_BASE_ADDRESS_IDX && !ps_wr
    |=> ps_rdata == {$past(ps_wdata[31:16], 3), 16'h0000})
    else $error("vector base readback wrong");

  AST_DIV_OFF: assert property (
    !q.div_en [*2] |-> tile_clk_en && !tile_clk_slow)
    else $error("clock slowed while divider disabled");

  AST_DYN_AWAKE: assert property (
    q.div_en && q.div_dyn && !cores_all_paused |=> !tile_clk_slow)
    else $error("dynamic divider slowed a running tile");

  AST_STATIC_SLOW: assert property (
    q.div_en && !q.div_dyn |=> tile_clk_slow)
    else $error("static divider not applied");

  AST_DIV_PULSE: assert property (
    tile_clk_en && slow_now && DIV_RATIO > 1 |=> !tile_clk_en)
    else $error("divided enable pulse longer than one cycle");

  AST_BOOT_READ: assert property (
    ps_rvalid && $past(ps_num) == TILE_BOOT_STATUS_IDX && $past(q.captured)
    |-> ps_rdata[31:24] == 8'h00 && ps_rdata[15:9] == 7'h00
        && ps_rdata[23:16] == q.tile_num && ps_rdata[8] == q.otp_boot
        && ps_rdata[7:0] == q.boot_pins)
    else $error("boot status readback wrong");

  AST_SEC_READ: assert property (
    ps_rvalid && $past(ps_num) == SECURITY_CONFIG_COPY_IDX
    && $past(q.captured)
    |-> ps_rdata == q.sec_word)
    else $error("security word readback wrong");

  AST_RO_WRITE: assert property (
    ps_wr && ps_num == SECURITY_CONFIG_COPY_IDX && q.captured
    |=> $stable(q.sec_word))
    else $error("write changed a read-only register");

  AST_OSC_CTRL: assert property (
    ps_wr && ps_num == OSCILLATOR_CONTROL_IDX
    |=> osc_tile_run == $past(ps_wdata[1])
        && osc_periph_run == $past(ps_wdata[0]))
    else $error("oscillator enables not taken from control");

  AST_OSC_READ: assert property (
    ps_rd && ps_num == PERIPH_WIRE_OSC_COUNT_IDX
    |=> ps_rdata == {16'h0000, $past(cnt_pw)})
    else $error("peripheral wire count readback wrong");

  AST_OSC_HOLD: assert property (
    !osc_tile_run [*4] |-> $stable(cnt_tc) && $stable(cnt_tw))
    else $error("stopped tile oscillator count moved");

  AST_UNMAPPED: assert property (
    ps_rd && ps_num == 8'h04 |=> ps_rvalid && ps_rdata == 32'h0)
    else $error("unmapped number did not read zero");

  AST_READ_ANSWER: assert property (
    ps_rd |=> ps_rvalid)
    else $error("read request got no answer");

  AST_READ_PULSE: assert property (
    !ps_rd |=> !ps_rvalid)
    else $error("read answer without a request");

  AST_VEC_RESERVED: assert property (
    ps_rvalid && $past(ps_num) == VECTOR_BASE_ADDRESS_IDX
    |-> ps_rdata[15:0] == 16'h0000)
    else $error("vector base reserved bits not zero");

  AST_CTRL_RESERVED: assert property (
    ps_rvalid && $past(ps_num) == TILE_POWER_CONTROL_IDX
    |-> ps_rdata[31:6] == 26'h0 && ps_rdata[3:0] == 4'h0)
    else $error("tile control reserved bits not zero");

  AST_COUNT_RESERVED: assert property (
    ps_rvalid && $past(ps_num) >= TILE_CELL_OSC_COUNT_IDX
    && $past(ps_num) <= PERIPH_WIRE_OSC_COUNT_IDX
    |-> ps_rdata[31:16] == 16'h0000)
    else $error("oscillator count reserved bits not zero");

  AST_DIV_RESET: assert property (
    $rose(rstn) |-> tile_clk_en && !tile_clk_slow)
    else $error("divider not idle after reset");

  AST_OSC_RESET: assert property (
    $rose(rstn) |-> !osc_tile_run && !osc_periph_run)
    else $error("oscillators not stopped after reset");

  AST_VEC_PULSE: assert property (
    !vec_take |=> !vec_addr_valid)
    else $error("vector address valid without a take");

endmodule : psr_status_bank

// ===== verilog/psr_pkg.sv
// psr_pkg: constants for the processor status register bank.
// assumes: one tile clock, word-wide status-register reads and writes.
//
// Behaviour
// - bank reached only by status-register reads/writes
// - ram base resets to 0x00010000
// - ram base bits 31:2 writable, 1:0 reserved
// - vector address: base upper half, resource lower half
// - vector base bits 31:16 writable, rest reserved
// - control bit 4 enables power divider, resets 0
// - bit 5 dynamic: slow only when cores paused
// - boot status 23:16 holds tile switch number
// - boot status bit 8 flags OTP boot
// - boot status 7:0 shows sampled boot pins
// - read-only copy of OTP security word
// - four oscillator counters, software start/stop
// - bit 1 tile pair, bit 0 peripheral pair
// - counts at 0x07..0x0a, 16 bits, ordered
// - oscillator counts survive system reset
// - oscillators asynchronous to tile clock
package psr_pkg;

  // ---------------------------------------------------------------
  // register numbers
  // ---------------------------------------------------------------
  localparam logic [7:0] RAM_BASE_ADDRESS_IDX      = 8'h00;
  localparam logic [7:0] VECTOR_BASE_ADDRESS_IDX   = 8'h01;
  localparam logic [7:0] TILE_POWER_CONTROL_IDX    = 8'h02;
  localparam logic [7:0] TILE_BOOT_STATUS_IDX      = 8'h03;
  localparam logic [7:0] SECURITY_CONFIG_COPY_IDX  = 8'h05;
  localparam logic [7:0] OSCILLATOR_CONTROL_IDX    = 8'h06;
  localparam logic [7:0] TILE_CELL_OSC_COUNT_IDX   = 8'h07;
  localparam logic [7:0] TILE_WIRE_OSC_COUNT_IDX   = 8'h08;
  localparam logic [7:0] PERIPH_CELL_OSC_COUNT_IDX = 8'h09;
  localparam logic [7:0] PERIPH_WIRE_OSC_COUNT_IDX = 8'h0a;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RAM_BASE_RST     = 32'h0001_0000;
  localparam int          RAM_BASE_LSB     = 2;
  localparam int          VEC_BASE_LSB     = 16;
  localparam int          DIV_EN_BIT       = 4;
  localparam int          DIV_DYN_BIT      = 5;
  localparam int          BOOT_TILE_LSB    = 16;
  localparam int          BOOT_OTP_BIT     = 8;
  localparam int          OSC_TILE_BIT     = 1;
  localparam int          OSC_PERIPH_BIT   = 0;
  localparam int          OSC_COUNT_W      = 16;
  localparam logic [1:0]  BOOT_CAPTURE_CNT = 2'h2;

endpackage : psr_pkg

// ===== verilog/psr_osc_count.sv
// psr_osc_count: counts rising edges of one free-running ring oscillator.
// assumes: osc_in is asynchronous to mclk and toggles well below mclk/2.
`timescale 1ns/100ps
module psr_osc_count #(
  parameter int W = 16
) (
  // clock
  input  wire logic         mclk,
  // control and oscillator
  input  wire logic         run,
  input  wire logic         osc_in,
  // count
  output logic [W-1:0]      count
);

  typedef struct packed {
    logic         s1;
    logic         s2;
    logic         s3;
    logic [W-1:0] cnt;
  } psr_osc_st_t;

  // power-up contents only: no reset ever clears the count
  psr_osc_st_t q = '0;
  psr_osc_st_t d;

  // ---------------------------------------------------------------
  // edge counter in the tile domain
  // ---------------------------------------------------------------
  // no reset on purpose: the count must survive a system reset
  always_comb begin
    d    = q;
    d.s1 = osc_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (run && q.s2 && !q.s3) begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign count = q.cnt;

endmodule : psr_osc_count

// ===== verif/psr_osc_model.sv
// psr_osc_model: stand-in for the four free-running ring oscillators.
// assumes: a rising edge on go starts one burst of edges on every line;
// line i gives EDGES+i rising edges, on its own unrelated period.
`timescale 1ns/100ps
module psr_osc_model #(
  parameter int EDGES = 4
) (
  // burst request
  input  wire logic       go,
  // oscillator lines: tile cell, tile wire, periph cell, periph wire
  output wire logic [3:0] osc
);
  // ---------------------------------------------------------------
  // lines
  // ---------------------------------------------------------------
  // half periods are above two tile cycles and share no ratio with
  // the tile clock, so edges land at every phase
  localparam int HALF [4] = '{47, 53, 61, 71};

  for (genvar i = 0; i < 4; i++) begin : g_line
    logic line_q;
    initial line_q = 1'b0;
    assign osc[i] = line_q;
    always @(posedge go) begin
      repeat (EDGES + i) begin
        #(HALF[i]) line_q = 1'b1;
        #(HALF[i]) line_q = 1'b0;
      end
    end
  end
endmodule : psr_osc_model

// ===== verif/tb.sv
// tb: self-checking bench for the processor status register bank.
// assumes: the bench plays the local core on the status bus; the
// oscillator model drives the four oscillator inputs.
`timescale 1ns/100ps
module tb;
  import psr_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int DIV   = 2;
  localparam int EDGES = 4;
  logic        mclk, rstn, ps_rd, ps_wr, vec_take, paused, otp_en, go;
  logic [7:0]  ps_num, pins, tile_num;
  logic [31:0] ps_wdata, sec_word, ps_rdata, vec_addr, ram_base;
  logic [15:0] vec_resource;
  logic        ps_rvalid, vec_addr_valid, tile_clk_en, tile_clk_slow;
  logic        osc_tile_run, osc_periph_run;
  logic [3:0]  osc;
  logic [31:0] saved [4];
  int          failures, num_checks;

  `define CHK(nm, exp, got) begin num_checks++; \
    if ((got) !== (exp)) begin failures++; \
      $display("unexpected %s exp %h got %h", nm, exp, got); end end

  psr_status_bank #(.DIV_RATIO(DIV)) dut (
    .mclk(mclk), .rstn(rstn), .ps_rd(ps_rd), .ps_wr(ps_wr),
    .ps_num(ps_num), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .ps_rvalid(ps_rvalid), .vec_take(vec_take),
    .vec_resource(vec_resource), .vec_addr(vec_addr),
    .vec_addr_valid(vec_addr_valid), .ram_base(ram_base),
    .cores_all_paused(paused), .tile_clk_en(tile_clk_en),
    .tile_clk_slow(tile_clk_slow), .boot_select_pins(pins),
    .switch_tile_num(tile_num), .otp_boot_enabled(otp_en),
    .otp_security_word(sec_word), .osc_tile_run(osc_tile_run),
    .osc_periph_run(osc_periph_run), .osc_tile_cell(osc[0]),
    .osc_tile_wire(osc[1]), .osc_periph_cell(osc[2]),
    .osc_periph_wire(osc[3]));

  psr_osc_model #(.EDGES(EDGES)) u_osc (.go(go), .osc(osc));

  always #10 mclk = ~mclk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic end_test(input string nm);
    $display("test %s done, failures so far %0d", nm, failures);
  endtask : end_test

  task automatic ps_write(input logic [7:0] num, input logic [31:0] d);
    @(posedge mclk); #2;
    ps_wr = 1'b1; ps_num = num; ps_wdata = d;
    @(posedge mclk); #2;
    ps_wr = 1'b0;
  endtask : ps_write

  // answer is due right at the taking edge; a short bound
  // catches a lost read instead of hanging
  task automatic ps_read(input logic [7:0] num, output logic [31:0] d);
    int n;
    @(posedge mclk); #2;
    ps_rd = 1'b1; ps_num = num;
    @(posedge mclk); #2;
    ps_rd = 1'b0;
    n = 0;
    while (ps_rvalid !== 1'b1 && n < 4) begin
      @(posedge mclk); #2;
      n++;
    end
    if (n == 4) begin
      failures++;
      $display("unexpected ps_rvalid exp 1 got %b num %h", ps_rvalid, num);
      stop_test();
    end
    d = ps_rdata;
  endtask : ps_read

  task automatic rd_chk(input logic [7:0] num, input logic [31:0] e,
                        input string nm);
    logic [31:0] d;
    ps_read(num, d);
    `CHK(nm, e, d)
  endtask : rd_chk

  task automatic vec_chk(input logic [15:0] r, input logic [31:0] e);
    @(posedge mclk); #2;
    vec_take = 1'b1; vec_resource = r;
    @(posedge mclk); #2;
    vec_take = 1'b0;
    `CHK("vec_valid", 1'b1, vec_addr_valid)
    `CHK("vec_addr", e, vec_addr)
  endtask : vec_chk

  // counts clock enables over eight cycles once the mode has settled
  task automatic div_chk(input logic [31:0] ctl, input logic p,
                         input logic s);
    int n;
    ps_write(TILE_POWER_CONTROL_IDX, ctl);
    paused = p;
    repeat (3) @(posedge mclk);
    #2;
    `CHK("clk_slow", s, tile_clk_slow)
    n = 0;
    repeat (8) begin
      @(posedge mclk); #2;
      if (tile_clk_en === 1'b1) n++;
    end
    `CHK("clk_en_count", (s ? 8 / DIV : 8), n)
  endtask : div_chk

  // counts are never reset, so only the growth over one burst is
  // judged; an unknown starting count leaves only the upper half
  task automatic osc_chk(input logic [1:0] ctl);
    logic [31:0] base [4];
    logic [31:0] d;
    logic [3:0]  on;
    logic [15:0] exp16;
    on = {ctl[0], ctl[0], ctl[1], ctl[1]};
    ps_write(OSCILLATOR_CONTROL_IDX, {30'h0, ctl});
    `CHK("osc_run", ctl, {osc_tile_run, osc_periph_run})
    for (int i = 0; i < 4; i++)
      ps_read(TILE_CELL_OSC_COUNT_IDX + 8'(i), base[i]);
    go = 1'b1;
    @(posedge mclk); #2;
    go = 1'b0;
    repeat (100) @(posedge mclk);
    ps_write(OSCILLATOR_CONTROL_IDX, 32'h0);
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      ps_read(TILE_CELL_OSC_COUNT_IDX + 8'(i), d);
      `CHK("osc_hi", 16'h0, d[31:16])
      exp16 = base[i][15:0] + (on[i] ? 16'(EDGES + i) : 16'h0);
      if (!$isunknown(base[i]))
        `CHK("osc_count", exp16, d[15:0])
    end
  endtask : osc_chk

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    failures = 0; num_checks = 0;
    mclk = 1'b0; rstn = 1'b0; ps_rd = 1'b0; ps_wr = 1'b0;
    ps_num = 8'h00; ps_wdata = 32'h0; vec_take = 1'b0;
    vec_resource = 16'h0; paused = 1'b0; go = 1'b0;
    pins = 8'ha5; tile_num = 8'h3c; otp_en = 1'b1;
    sec_word = 32'h5ec0_c0de;
    repeat (5) @(posedge mclk);
    #2 rstn = 1'b1;
    repeat (5) @(posedge mclk);
    rd_chk(8'h00, 32'h0001_0000, "ram_base_rd");
    `CHK("ram_base", 32'h0001_0000, ram_base)
    rd_chk(8'h02, 32'h0, "tile_ctl_rst");
    rd_chk(8'h06, 32'h0, "osc_ctl_rst");
    rd_chk(8'h03, 32'h003c_01a5, "boot_status");
    rd_chk(8'h05, 32'h5ec0_c0de, "security");
    end_test("reset_values");
    ps_write(8'h00, 32'hffff_ffff);
    rd_chk(8'h00, 32'hffff_fffc, "ram_base_mask");
    `CHK("ram_base_port", 32'hffff_fffc, ram_base)
    ps_write(8'h01, 32'hffff_ffff);
    rd_chk(8'h01, 32'hffff_0000, "vec_base_mask");
    ps_write(8'h02, 32'hffff_ffff);
    rd_chk(8'h02, 32'h0000_0030, "tile_ctl_mask");
    ps_write(8'h06, 32'hffff_ffff);
    rd_chk(8'h06, 32'h0000_0003, "osc_ctl_mask");
    ps_write(8'h03, 32'h0);
    ps_write(8'h05, 32'h0);
    ps_write(8'h04, 32'hffff_ffff);
    rd_chk(8'h03, 32'h003c_01a5, "boot_ro");
    rd_chk(8'h05, 32'h5ec0_c0de, "security_ro");
    rd_chk(8'h04, 32'h0, "unmapped");
    end_test("masks");
    ps_write(8'h01, 32'h8a5c_0000);
    vec_chk(16'h1234, 32'h8a5c_1234);
    vec_chk(16'hfffe, 32'h8a5c_fffe);
    end_test("vectors");
    div_chk(32'h10, 1'b0, 1'b1);
    div_chk(32'h30, 1'b0, 1'b0);
    div_chk(32'h30, 1'b1, 1'b1);
    div_chk(32'h20, 1'b1, 1'b0);
    end_test("divider");
    osc_chk(2'b11);
    osc_chk(2'b10);
    osc_chk(2'b01);
    osc_chk(2'b00);
    end_test("oscillators");
    for (int i = 0; i < 4; i++)
      ps_read(TILE_CELL_OSC_COUNT_IDX + 8'(i), saved[i]);
    @(posedge mclk); #2;
    rstn = 1'b0; pins = 8'h5a; otp_en = 1'b0;
    repeat (5) @(posedge mclk);
    #2 rstn = 1'b1;
    repeat (5) @(posedge mclk);
    for (int i = 0; i < 4; i++)
      rd_chk(TILE_CELL_OSC_COUNT_IDX + 8'(i), saved[i], "kept");
    rd_chk(8'h00, 32'h0001_0000, "ram_base_rerst");
    rd_chk(8'h06, 32'h0, "osc_ctl_rerst");
    rd_chk(8'h03, 32'h003c_005a, "boot_otp_off");
    end_test("second_reset");
    stop_test();
  end
endmodule : tb
